/* File: src/lbc_pkg.sv */
// Constants and types shared by the LED brightness control path
package lbc_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_BRIGHTNESS_LOW = 8'h18;
  localparam logic [7:0] ADDR_BRIGHTNESS_HIGH = 8'h19;
  localparam logic [7:0] BRIGHTNESS_RESET = 8'h00;
  localparam int LOW_BITS = 3;
  localparam logic [10:0] CODE_FULL = 11'h07ff;
  localparam logic [10:0] CODE_ZERO = 11'h0000;

  // ==========================================================
  // Brightness modes
  typedef enum logic [1:0] {
    LBC_MODE_I2C = 2'b00,
    LBC_MODE_PWM = 2'b01,
    LBC_MODE_MUL_RAMP = 2'b10,
    LBC_MODE_RAMP_MUL = 2'b11
  } lbc_mode_t;

  // ==========================================================
  // Timing
  localparam int F_CLK_KHZ = 100000;
  localparam int SAMP_SLOW_KHZ = 800;
  localparam int SAMP_MID_KHZ = 4000;
  localparam int SAMP_FAST_KHZ = 24000;
  localparam int DIV_SLOW = F_CLK_KHZ / SAMP_SLOW_KHZ;
  localparam int DIV_MID = F_CLK_KHZ / SAMP_MID_KHZ;
  localparam int DIV_FAST = F_CLK_KHZ / SAMP_FAST_KHZ;
  localparam int TO_SLOW_US = 25000;
  localparam int TO_MID_US = 3000;
  localparam int TO_FAST_US = 600;
  localparam int TO_SLOW_SAMP = TO_SLOW_US * SAMP_SLOW_KHZ / 1000;
  localparam int TO_MID_SAMP = TO_MID_US * SAMP_MID_KHZ / 1000;
  localparam int TO_FAST_SAMP = TO_FAST_US * SAMP_FAST_KHZ / 1000;
  // Ramp rate 0 is one step per microsecond, about 2 ms full scale
  localparam int STEP_BASE_NS = 1000;
  localparam int STEP_BASE_CYC = STEP_BASE_NS * F_CLK_KHZ / 1000000;

  // ==========================================================
  // Register port and state
  typedef struct packed {
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lbc_reg_req_t;

  typedef struct packed {
    logic [2:0] pin;
    logic lvl;
    logic lvl_d;
    logic [6:0] div;
    logic [15:0] per_cnt;
    logic [15:0] hi_cnt;
    logic [10:0] duty;
    logic timeout;
    logic [7:0] low;
    logic [7:0] high;
    logic [10:0] i2c;
    logic [16:0] tmr;
    logic [10:0] ramp;
    logic [10:0] led;
    logic boost_off;
  } lbc_state_t;
endpackage

/* File: src/lbc_path.sv */
// Brightness path: PWM duty sampling, timeout, modes and current ramper
`timescale 1ns/1ps

module lbc_path #(
  parameter logic [16:0] STEP_BASE = 17'(lbc_pkg::STEP_BASE_CYC),
  parameter logic [15:0] TO_SLOW = 16'(lbc_pkg::TO_SLOW_SAMP),
  parameter logic [15:0] TO_MID = 16'(lbc_pkg::TO_MID_SAMP),
  parameter logic [15:0] TO_FAST = 16'(lbc_pkg::TO_FAST_SAMP)
) (
  input wire logic mclk, // 100 MHz clock
  input wire logic rstn, // Asynchronous reset, active low
  input wire logic pwm_in, // PWM dimming pin
  input wire lbc_pkg::lbc_mode_t mode, // Brightness mode field
  input wire logic [2:0] ramp_rate, // Time per step select
  input wire logic [1:0] sample_rate, // 0 slow, 1 mid, 1x fast
  input wire lbc_pkg::lbc_reg_req_t reg_req, // Register write request
  output logic [7:0] reg_rdata, // Register read data for reg_req.addr
  output logic [10:0] led_code, // Code to the current mapper
  output logic [10:0] duty_code, // Measured PWM duty code
  output logic boost_off // Boost shut off by PWM loss
);
  // ==========================================================
  // Reset release
  logic [1:0] rst_sync_r;
  logic rst_n;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // ==========================================================
  // Arithmetic helpers
  function automatic logic [10:0] lbc_scale(input logic [10:0] a,
                                            input logic [10:0] b);
    logic [21:0] p;
    p = (22'(a) * 22'(b)) / 22'(lbc_pkg::CODE_FULL);
    return p[10:0];
  endfunction

  function automatic logic [10:0] lbc_duty(input logic [15:0] hi,
                                           input logic [15:0] per);
    logic [26:0] q;
    q = 27'(0);
    if (per != 16'h0000)
      q = (27'(hi) * 27'(lbc_pkg::CODE_FULL)) / 27'(per);
    if (q > 27'(lbc_pkg::CODE_FULL))
      q = 27'(lbc_pkg::CODE_FULL);
    return q[10:0];
  endfunction

  // ==========================================================
  // State
  lbc_pkg::lbc_state_t st_r;
  lbc_pkg::lbc_state_t st_nxt;
  logic samp;
  logic rise;
  logic step;
  logic [6:0] div_max;
  logic [15:0] to_lim;
  logic [10:0] target;
  logic [16:0] step_cyc;
  logic pwm_used;

  always_comb
  begin
    unique case (sample_rate)
      2'b00:
      begin
        div_max = 7'(lbc_pkg::DIV_SLOW - 1);
        to_lim = TO_SLOW;
      end
      2'b01:
      begin
        div_max = 7'(lbc_pkg::DIV_MID - 1);
        to_lim = TO_MID;
      end
      default:
      begin
        div_max = 7'(lbc_pkg::DIV_FAST - 1);
        to_lim = TO_FAST;
      end
    endcase
  end

  assign samp = (st_r.div == div_max);
  assign rise = samp && st_r.lvl && !st_r.lvl_d;
  assign pwm_used = (mode != lbc_pkg::LBC_MODE_I2C);
  assign step_cyc = STEP_BASE << ramp_rate;

  always_comb
  begin
    unique case (mode)
      lbc_pkg::LBC_MODE_I2C: target = st_r.i2c;
      lbc_pkg::LBC_MODE_PWM: target = st_r.duty;
      lbc_pkg::LBC_MODE_MUL_RAMP:
        target = lbc_scale(st_r.i2c, st_r.duty);
      lbc_pkg::LBC_MODE_RAMP_MUL: target = st_r.i2c;
    endcase
  end

  assign step = (st_r.tmr == 17'h0_0000) && (st_r.ramp != target);

  always_comb
  begin
    st_nxt = st_r;
    // Pin filter: a level counts once the last two stages agree
    st_nxt.pin = {st_r.pin[1:0], pwm_in};
    if (st_r.pin[2] == st_r.pin[1])
      st_nxt.lvl = st_r.pin[1];
    st_nxt.div = samp ? 7'h00 : st_r.div + 7'h01;
    if (samp)
    begin
      st_nxt.lvl_d = st_r.lvl;
      if (rise)
      begin
        st_nxt.duty = lbc_duty(st_r.hi_cnt, st_r.per_cnt);
        st_nxt.per_cnt = 16'h0001;
        st_nxt.hi_cnt = 16'h0001;
        st_nxt.timeout = 1'b0;
      end
      else
      begin
        if (st_r.per_cnt != 16'hffff)
          st_nxt.per_cnt = st_r.per_cnt + 16'h0001;
        if (st_r.lvl && st_r.hi_cnt != 16'hffff)
          st_nxt.hi_cnt = st_r.hi_cnt + 16'h0001;
        if (st_r.per_cnt >= to_lim)
        begin
          st_nxt.timeout = 1'b1;
          st_nxt.duty = st_r.lvl ? lbc_pkg::CODE_FULL : lbc_pkg::CODE_ZERO;
        end
      end
    end
    st_nxt.boost_off = st_r.timeout && pwm_used;
    // Registers: the target moves only when the high bits land
    if (reg_req.wr_en && reg_req.addr == lbc_pkg::ADDR_BRIGHTNESS_LOW)
      st_nxt.low = reg_req.wdata;
    if (reg_req.wr_en && reg_req.addr == lbc_pkg::ADDR_BRIGHTNESS_HIGH)
    begin
      st_nxt.high = reg_req.wdata;
      st_nxt.i2c = {reg_req.wdata,
                    st_r.low[lbc_pkg::LOW_BITS-1:0]};
    end
    // Ramper: first step is immediate, later steps one interval apart
    if (st_r.ramp == target)
      st_nxt.tmr = 17'h0_0000;
    else if (step)
    begin
      st_nxt.tmr = step_cyc - 17'h0_0001;
      st_nxt.ramp = (st_r.ramp < target) ? st_r.ramp + 11'h001
                                         : st_r.ramp - 11'h001;
    end
    else
      st_nxt.tmr = st_r.tmr - 17'h0_0001;
    if (mode == lbc_pkg::LBC_MODE_RAMP_MUL)
      st_nxt.led = lbc_scale(st_r.ramp, st_r.duty);
    else
      st_nxt.led = st_r.ramp;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      st_r.low <= lbc_pkg::BRIGHTNESS_RESET;
      st_r.high <= lbc_pkg::BRIGHTNESS_RESET;
    end
    else
      st_r <= st_nxt;
  end

  always_comb
  begin
    unique case (reg_req.addr)
      lbc_pkg::ADDR_BRIGHTNESS_LOW: reg_rdata = st_r.low;
      lbc_pkg::ADDR_BRIGHTNESS_HIGH: reg_rdata = st_r.high;
      default: reg_rdata = 8'h00;
    endcase
  end

  assign led_code = st_r.led;
  assign duty_code = st_r.duty;
  assign boost_off = st_r.boost_off;

  // ==========================================================
  // Assertions
  property p_low_write_holds;
    @(posedge mclk) disable iff (!rst_n)
    reg_req.wr_en && reg_req.addr != lbc_pkg::ADDR_BRIGHTNESS_HIGH
      |=> $stable(st_r.i2c);
  endproperty
  a_low_write_holds: assert property (p_low_write_holds)
    else $error("Brightness target moved without high write");

  property p_high_join;
    @(posedge mclk) disable iff (!rst_n)
    reg_req.wr_en && reg_req.addr == lbc_pkg::ADDR_BRIGHTNESS_HIGH
      |=> st_r.i2c == {$past(reg_req.wdata),
                       $past(st_r.low[lbc_pkg::LOW_BITS-1:0])};
  endproperty
  a_high_join: assert property (p_high_join)
    else $error("Brightness code not joined from registers");

  property p_one_step;
    @(posedge mclk) disable iff (!rst_n)
    st_r.ramp != $past(st_r.ramp) |->
      (st_r.ramp - $past(st_r.ramp) == 11'h001) ||
      ($past(st_r.ramp) - st_r.ramp == 11'h001);
  endproperty
  a_one_step: assert property (p_one_step)
    else $error("Ramper moved by more than one code");

  property p_step_gap;
    @(posedge mclk) disable iff (!rst_n)
    step |=> !step && st_r.tmr == $past(step_cyc) - 17'h0_0001;
  endproperty
  a_step_gap: assert property (p_step_gap)
    else $error("Ramp steps closer than the interval");

  property p_toward;
    @(posedge mclk) disable iff (!rst_n)
    step && st_r.ramp < target |=> st_r.ramp == $past(st_r.ramp) + 11'h001;
  endproperty
  a_toward: assert property (p_toward)
    else $error("Ramper did not move toward target");

  property p_i2c_only;
    @(posedge mclk) disable iff (!rst_n)
    mode == lbc_pkg::LBC_MODE_I2C |-> target == st_r.i2c;
  endproperty
  a_i2c_only: assert property (p_i2c_only)
    else $error("Mode 00 target not from registers");

  property p_pwm_only;
    @(posedge mclk) disable iff (!rst_n)
    mode == lbc_pkg::LBC_MODE_PWM |-> target == st_r.duty;
  endproperty
  a_pwm_only: assert property (p_pwm_only)
    else $error("Mode 01 target not from duty");

  property p_ramp_mul;
    @(posedge mclk) disable iff (!rst_n)
    mode == lbc_pkg::LBC_MODE_RAMP_MUL && $stable(mode)
      |=> led_code == lbc_scale($past(st_r.ramp), $past(st_r.duty));
  endproperty
  a_ramp_mul: assert property (p_ramp_mul)
    else $error("Mode 11 output not ramp times duty");

  property p_boost_off;
    @(posedge mclk) disable iff (!rst_n)
    st_r.timeout && pwm_used |=> boost_off;
  endproperty
  a_boost_off: assert property (p_boost_off)
    else $error("Boost not shut off on PWM loss");

  c_full: cover property (@(posedge mclk) disable iff (!rst_n)
    led_code == lbc_pkg::CODE_FULL);
  c_timeout: cover property (@(posedge mclk) disable iff (!rst_n)
    boost_off);
  c_rise: cover property (@(posedge mclk) disable iff (!rst_n)
    rise ##1 step);
endmodule

/* File: testbench/lbc_pwm_src.sv */
// Logic-level PWM source standing at the far side of the pin
`timescale 1ns/1ps
module lbc_pwm_src #(
  parameter int PER = 40
) (
  input wire logic mclk, // Source clock
  input wire logic en, // Pulses run while high
  input wire logic [7:0] hi_cyc, // High time in cycles
  output logic pwm // PWM output, low while stopped
);
  int cnt = 0;

  // ==========================================================
  // Fixed period keeps edges on a whole number of fast-rate sample ticks
  always @(posedge mclk)
  begin
    cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
    pwm <= #1 en && (cnt < int'(hi_cyc));
  end
endmodule

/* File: testbench/tb_top.sv */
// Self-checking testbench for the LED brightness control path
`timescale 1ns/1ps
module tb_top;
  logic mclk;
  logic rstn;
  logic pwm_en;
  logic [7:0] pwm_hi;
  logic pwm_in;
  lbc_pkg::lbc_mode_t mode;
  logic [2:0] ramp_rate;
  logic [1:0] sample_rate;
  lbc_pkg::lbc_reg_req_t reg_req;
  logic [7:0] reg_rdata;
  logic [10:0] led_code;
  logic [10:0] duty_code;
  logic boost_off;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;

  // ==========================================================
  // Design, with short step and timeout counts
  lbc_path #(
    .STEP_BASE(17'h0_0002),
    .TO_SLOW(16'h0014),
    .TO_MID(16'h0014),
    .TO_FAST(16'h0014)
  ) uut (
    .mclk(mclk),
    .rstn(rstn),
    .pwm_in(pwm_in),
    .mode(mode),
    .ramp_rate(ramp_rate),
    .sample_rate(sample_rate),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .led_code(led_code),
    .duty_code(duty_code),
    .boost_off(boost_off)
  );

  lbc_pwm_src #(.PER(40)) src (
    .mclk(mclk),
    .en(pwm_en),
    .hi_cyc(pwm_hi),
    .pwm(pwm_in)
  );

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [10:0] seen,
                       input logic [10:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %0d seen %0d", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req = '{wr_en: 1'b1, addr: a, wdata: d};
    tick(1);
    reg_req.wr_en = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_req.addr = a;
    tick(1);
    check("reg_rdata", {3'h0, reg_rdata}, {3'h0, exp});
  endtask

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fail_count++;
      complete_run();
    end
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    rstn = 1'b0;
    pwm_en = 1'b0;
    pwm_hi = 8'h14;
    mode = lbc_pkg::LBC_MODE_I2C;
    ramp_rate = 3'h0;
    sample_rate = 2'h2;
    reg_req = '0;
    tick(8);
    rstn = 1'b1;
    tick(3);
    check("led_code", led_code, lbc_pkg::CODE_ZERO);
    rd(lbc_pkg::ADDR_BRIGHTNESS_HIGH, lbc_pkg::BRIGHTNESS_RESET);
    wr(lbc_pkg::ADDR_BRIGHTNESS_LOW, 8'hff);
    rd(lbc_pkg::ADDR_BRIGHTNESS_LOW, 8'hff);
    rd(8'h20, 8'h00);
    tick(20);
    check("led_code", led_code, lbc_pkg::CODE_ZERO);
    wr(lbc_pkg::ADDR_BRIGHTNESS_HIGH, 8'h12);
    tick(100);
    check("ramp_busy", {10'h000, led_code < 11'h097}, 11'h001);
    tick(250);
    check("led_code", led_code, 11'h097);
    check("boost_off", {10'h000, boost_off}, 11'h000);
    pwm_en = 1'b1;
    tick(200);
    check("led_code", led_code, 11'h097);
    mode = lbc_pkg::LBC_MODE_PWM;
    tick(2500);
    check("duty_code", duty_code, 11'h3ff);
    check("led_code", led_code, 11'h3ff);
    mode = lbc_pkg::LBC_MODE_MUL_RAMP;
    tick(2200);
    check("led_code", led_code, 11'h04b);
    mode = lbc_pkg::LBC_MODE_RAMP_MUL;
    tick(400);
    check("led_code", led_code, 11'h04b);
    ramp_rate = 3'h7;
    pwm_hi = 8'h20;
    tick(200);
    check("duty_code", duty_code, 11'h665);
    check("led_code", led_code, 11'h078);
    mode = lbc_pkg::LBC_MODE_I2C;
    tick(10);
    wr(lbc_pkg::ADDR_BRIGHTNESS_HIGH, 8'h13);
    tick(1000);
    check("led_code", led_code, 11'h09b);
    tick(1000);
    check("led_code", led_code, 11'h09f);
    mode = lbc_pkg::LBC_MODE_PWM;
    ramp_rate = 3'h0;
    pwm_hi = 8'h14;
    tick(100);
    pwm_en = 1'b0;
    tick(40);
    check("boost_off", {10'h000, boost_off}, 11'h000);
    tick(160);
    check("boost_off", {10'h000, boost_off}, 11'h001);
    check("duty_code", duty_code, lbc_pkg::CODE_ZERO);
    pwm_en = 1'b1;
    tick(100);
    check("boost_off", {10'h000, boost_off}, 11'h000);
    // Change rate while pulses run, so the count restarts at the new rate
    sample_rate = 2'h1;
    tick(400);
    check("boost_off", {10'h000, boost_off}, 11'h000);
    pwm_en = 1'b0;
    tick(200);
    check("boost_off", {10'h000, boost_off}, 11'h000);
    tick(500);
    check("boost_off", {10'h000, boost_off}, 11'h001);
    pwm_en = 1'b1;
    sample_rate = 2'h0;
    tick(2000);
    check("boost_off", {10'h000, boost_off}, 11'h000);
    pwm_en = 1'b0;
    tick(1000);
    check("boost_off", {10'h000, boost_off}, 11'h000);
    tick(2000);
    check("boost_off", {10'h000, boost_off}, 11'h001);
    complete_run();
  end
endmodule
